/* verilog/reset_seq_pkg.sv */
// Shared constants for the reset source sequencer: register map, field
// positions, reset values, detector modes, start-up timing and states.
// Assumes a 125 MHz system clock and a 32-bit AXI4-Lite register bus.
package reset_seq_pkg;

	// Register byte offsets.
	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] CAUSE_OFF = 8'h04;

	// Brownout control fields and reset value.
	localparam int SWEN_BIT = 7;
	localparam int FS_BIT = 6;
	localparam int RDY_BIT = 0;
	localparam logic [7:0] CTRL_RESET = 8'h80;

	// Reset cause fields and their value after a power-on reset.
	localparam int OVF_BIT = 7;
	localparam int UNF_BIT = 6;
	localparam int TO_BIT = 5;
	localparam int PD_BIT = 4;
	localparam int RI_BIT = 3;
	localparam int POR_BIT = 1;
	localparam int BOR_BIT = 0;
	localparam logic [7:0] CAUSE_RESET = 8'h38;
	localparam logic [7:0] CAUSE_MASK = 8'hfb;

	// Brownout mode selection encodings.
	localparam logic [1:0] BO_OFF = 2'h0;
	localparam logic [1:0] BO_SW = 2'h1;
	localparam logic [1:0] BO_NOSLEEP = 2'h2;
	localparam logic [1:0] BO_ON = 2'h3;

	// Timing: clock period, power-up delay and clear-release delay.
	localparam int CLK_PERIOD_NS = 8;
	localparam int POWERUP_DELAY_TIMER_MS = 64;
	localparam int POWERUP_DELAY_TIMER_CYCLES = POWERUP_DELAY_TIMER_MS * 1000000 / CLK_PERIOD_NS;
	localparam int POWERUP_DELAY_TIMER_CNT_W = 23;
	localparam int CLR_DELAY_CYCLES = 10;
	localparam int CLR_DELAY_W = 4;
	localparam int FILT_CYCLES = 4;
	localparam int FILT_W = 2;

	// Bus responses.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Start-up sequence states.
	typedef enum logic [2:0] {ST_HOLD, ST_POWERUP_DELAY_TIMER, ST_READY, ST_DELAY, ST_RUN} seq_state_t;

endpackage

/* verilog/glitch_filter.sv */
// Noise filter for the external clear pin: the output follows the pin only
// after it has held a new level for a fixed number of samples.
// Assumes the pin is already synchronous to aclk.
`timescale 1ns/1ps
module glitch_filter (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Pin sample and filtered level.
	input wire logic raw,
	output logic level
);

	logic level_ff;
	logic [reset_seq_pkg::FILT_W-1:0] cnt_ff;

	assign level = level_ff;

	// Count consecutive samples that differ; short pulses restart the count.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			level_ff <= 1'b1;
			cnt_ff <= '0;
		end else if (raw == level_ff) begin
			cnt_ff <= '0;
		end else if (cnt_ff == reset_seq_pkg::FILT_W'(reset_seq_pkg::FILT_CYCLES - 1)) begin
			level_ff <= raw; // [R11]
			cnt_ff <= '0;
		end else begin
			cnt_ff <= cnt_ff + 1'b1;
		end
	end

	glitch_ignore_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R11]
		$fell(level_ff) |-> !$past(raw, 1) && !$past(raw, 2) && !$past(raw, 3) && !$past(raw, 4))
		else $error("Clear level fell without four low samples.");

endmodule

/* verilog/powerup_timer.sv */
// Power-up delay counter: restarts while held, then counts up to its
// length and raises done, which stays high until the next restart.
// Assumes restart is high for as long as a power source holds reset.
`timescale 1ns/1ps
module powerup_timer #(
	parameter int unsigned TICKS = reset_seq_pkg::POWERUP_DELAY_TIMER_CYCLES
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Control and status.
	input wire logic restart,
	output logic done
);

	logic [reset_seq_pkg::POWERUP_DELAY_TIMER_CNT_W-1:0] cnt_ff;
	logic done_ff;

	assign done = done_ff;

	// Count once per clock until the full delay has elapsed.
	always_ff @(posedge aclk) begin
		if (!aresetn || restart) begin
			cnt_ff <= '0;
			done_ff <= 1'b0;
		end else if (!done_ff) begin
			if (cnt_ff == reset_seq_pkg::POWERUP_DELAY_TIMER_CNT_W'(TICKS - 1)) begin
				done_ff <= 1'b1; // [R21]
			end
			cnt_ff <= cnt_ff + 1'b1;
		end
	end

endmodule

/* verilog/reset_source_sequencer.sv */
// Reset source collection and start-up sequencing with its brownout
// control and reset cause registers on an AXI4-Lite slave port.
// Assumes configuration bits are static and all inputs are synchronous.
// Operation
// [R1] Mode 01: software bit switches detector, no wait.
// [R2] Modes 10/01: fast start forces band gap on.
// [R3] Modes 11/00: fast start stored but ignored.
// [R4] Control bit 0 reads detector active status.
// [R5] Control bits 5..1 always read zero.
// [R6] Low-power detector trip holds reset, sets flag.
// [R7] Low-power detector enabled by active-low config bit.
// [R8] Use low-power detector with modes 00/10.
// [R9] Clear pin enabled by program bit or enable.
// [R10] Enabled clear pin held low holds reset.
// [R11] Short glitches on clear pin are ignored.
// [R12] Clear pin is never driven low.
// [R13] Disabled clear pin: pull-up under software.
// [R14] Watchdog timeout resets, updates timeout/powerdown flags.
// [R15] Reset instruction resets, clears its flag.
// [R16] Enabled stack faults reset and set flags.
// [R17] Programming exit acts as power-on reset.
// [R18] Active-low config bit enables power-up delay.
// [R19] Run waits for timer and clear release.
// [R20] Timer independent of pin; run 10 cycles later.
// [R21] Power-up delay is 64 ms of reset.
// [R22] Modes 11/10 wait for detector readiness.
// [R23] Core hold is OR of all sources.
`timescale 1ns/1ps
module reset_source_sequencer #(
	parameter int unsigned POWERUP_DELAY_TIMER_CYCLES = reset_seq_pkg::POWERUP_DELAY_TIMER_CYCLES
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write channels.
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read channels.
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Configuration word bits.
	input wire logic [1:0] brownout_mode_select,
	input wire logic low_power_brownout_n,
	input wire logic external_clear_enable,
	input wire logic low_voltage_program,
	input wire logic powerup_timer_enable_n,
	input wire logic stack_fault_reset_enable,
	// Analog detector outputs.
	input wire logic por_active,
	input wire logic brownout_low,
	input wire logic brownout_settled,
	input wire logic low_power_brownout_low,
	// External clear pin and its software pull-up control.
	input wire logic external_clear_pin,
	input wire logic sw_pullup_enable,
	// Core events.
	input wire logic watchdog_timeout,
	input wire logic reset_instr,
	input wire logic stack_overflow,
	input wire logic stack_underflow,
	input wire logic prog_mode_exit,
	input wire logic sleep_mode,
	// Reset and analog control outputs.
	output logic core_reset_hold,
	output logic brownout_detector_on,
	output logic bandgap_force_on,
	output logic clear_pin_pullup,
	// Reset cause flags.
	output logic stack_overflow_flag,
	output logic stack_underflow_flag,
	output logic timeout_flag_n,
	output logic powerdown_flag_n,
	output logic reset_instr_flag_n,
	output logic por_flag_n,
	output logic brownout_flag_n
);

	// Detector on/off by mode, software enable and sleep state.
	function automatic logic det_enable(input logic [1:0] mode, input logic swen,
		input logic slp);
		unique case (mode)
			reset_seq_pkg::BO_ON: det_enable = 1'b1;
			reset_seq_pkg::BO_NOSLEEP: det_enable = !slp;
			reset_seq_pkg::BO_SW: det_enable = swen;
			default: det_enable = 1'b0;
		endcase
	endfunction

	// Register address decode shared by read and write paths.
	function automatic logic reg_mapped(input logic [7:0] addr);
		reg_mapped = (addr == reset_seq_pkg::CTRL_OFF) || (addr == reset_seq_pkg::CAUSE_OFF);
	endfunction

	reset_seq_pkg::seq_state_t state_ff, nxt_state;
	logic [reset_seq_pkg::CLR_DELAY_W-1:0] dly_ff;
	logic swen_ff, fs_ff, rdy_ff, det_on_ff, bandgap_ff, hold_ff, pullup_ff;
	logic [7:0] cause_ff;
	logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
	logic [7:0] awaddr_ff;
	logic [7:0] wdata_ff;
	logic wstrb_ff;
	logic [1:0] bresp_ff, rresp_ff;
	logic [31:0] rdata_ff;
	logic clr_level, powerup_delay_timer_done;
	logic bor_trip, low_power_brownout_trip, power_src, clr_en, clr_low;
	logic need_rdy, rdy_ok, evt_rst, do_wr, run_evt;

	// Outputs, all taken from flip-flops.
	assign awready = awready_ff;
	assign wready = wready_ff;
	assign bresp = bresp_ff;
	assign bvalid = bvalid_ff;
	assign arready = arready_ff;
	assign rdata = rdata_ff;
	assign rresp = rresp_ff;
	assign rvalid = rvalid_ff;
	assign core_reset_hold = hold_ff;
	assign brownout_detector_on = det_on_ff;
	assign bandgap_force_on = bandgap_ff;
	assign clear_pin_pullup = pullup_ff;
	assign stack_overflow_flag = cause_ff[reset_seq_pkg::OVF_BIT];
	assign stack_underflow_flag = cause_ff[reset_seq_pkg::UNF_BIT];
	assign timeout_flag_n = cause_ff[reset_seq_pkg::TO_BIT];
	assign powerdown_flag_n = cause_ff[reset_seq_pkg::PD_BIT];
	assign reset_instr_flag_n = cause_ff[reset_seq_pkg::RI_BIT];
	assign por_flag_n = cause_ff[reset_seq_pkg::POR_BIT];
	assign brownout_flag_n = cause_ff[reset_seq_pkg::BOR_BIT];

	// Clear pin filter; the pin is only ever sampled, never driven.
	glitch_filter u_filter (
		.aclk(aclk),
		.aresetn(aresetn),
		.raw(external_clear_pin), // [R12]
		.level(clr_level)
	);

	// Power-up delay, restarted by every power-level reset.
	powerup_timer #(
		.TICKS(POWERUP_DELAY_TIMER_CYCLES)
	) u_powerup_delay_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.restart(state_ff == reset_seq_pkg::ST_HOLD), // [R20]
		.done(powerup_delay_timer_done)
	);

	// Reset sources and readiness conditions.
	assign bor_trip = det_on_ff && brownout_settled && brownout_low;
	assign low_power_brownout_trip = !low_power_brownout_n && low_power_brownout_low; // [R6] [R7]
	assign power_src = por_active || bor_trip || low_power_brownout_trip || prog_mode_exit; // [R17]
	assign clr_en = low_voltage_program || external_clear_enable; // [R9]
	assign clr_low = clr_en && !clr_level; // [R10]
	assign need_rdy = (brownout_mode_select == reset_seq_pkg::BO_ON) ||
		(brownout_mode_select == reset_seq_pkg::BO_NOSLEEP); // [R22] [R1]
	assign rdy_ok = !need_rdy || rdy_ff;
	assign evt_rst = watchdog_timeout || reset_instr ||
		(stack_fault_reset_enable && (stack_overflow || stack_underflow)); // [R14] [R16]
	assign run_evt = (state_ff == reset_seq_pkg::ST_RUN) && evt_rst;

	// Start-up sequence; a power-level source overrides every state.
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			reset_seq_pkg::ST_HOLD: begin
				if (powerup_timer_enable_n) begin
					nxt_state = reset_seq_pkg::ST_READY; // [R18]
				end else begin
					nxt_state = reset_seq_pkg::ST_POWERUP_DELAY_TIMER;
				end
			end
			reset_seq_pkg::ST_POWERUP_DELAY_TIMER: begin
				if (powerup_delay_timer_done) begin
					nxt_state = reset_seq_pkg::ST_READY; // [R19] [R21]
				end
			end
			reset_seq_pkg::ST_READY: begin
				if (rdy_ok && !clr_low) begin
					nxt_state = reset_seq_pkg::ST_DELAY; // [R19] [R22]
				end
			end
			reset_seq_pkg::ST_DELAY: begin
				if (clr_low || !rdy_ok) begin
					nxt_state = reset_seq_pkg::ST_READY;
				end else if (dly_ff == reset_seq_pkg::CLR_DELAY_W'(reset_seq_pkg::CLR_DELAY_CYCLES - 1)) begin
					nxt_state = reset_seq_pkg::ST_RUN; // [R20]
				end
			end
			reset_seq_pkg::ST_RUN: begin
				if (clr_low || evt_rst || !rdy_ok) begin
					nxt_state = reset_seq_pkg::ST_READY; // [R10] [R22]
				end
			end
		endcase
		if (power_src) begin
			nxt_state = reset_seq_pkg::ST_HOLD; // [R6]
		end
	end

	// State register and core hold, which is high outside the run state.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= reset_seq_pkg::ST_HOLD;
			hold_ff <= 1'b1;
		end else begin
			state_ff <= nxt_state;
			hold_ff <= (nxt_state != reset_seq_pkg::ST_RUN); // [R23]
		end
	end

	// Cycle count of the clear-release delay.
	always_ff @(posedge aclk) begin
		if (!aresetn || state_ff != reset_seq_pkg::ST_DELAY) begin
			dly_ff <= '0;
		end else begin
			dly_ff <= dly_ff + 1'b1;
		end
	end

	// Analog controls: detector enable, readiness, band gap and pull-up.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			det_on_ff <= 1'b0;
			rdy_ff <= 1'b0;
			bandgap_ff <= 1'b0;
			pullup_ff <= 1'b1;
		end else begin
			det_on_ff <= det_enable(brownout_mode_select, swen_ff, sleep_mode); // [R1] [R22]
			rdy_ff <= det_on_ff && brownout_settled; // [R4]
			bandgap_ff <= fs_ff && ((brownout_mode_select == reset_seq_pkg::BO_SW) ||
				(brownout_mode_select == reset_seq_pkg::BO_NOSLEEP)); // [R2] [R3]
			pullup_ff <= clr_en || sw_pullup_enable; // [R10] [R13]
		end
	end

	// Brownout control register; power-level resets restore defaults.
	always_ff @(posedge aclk) begin
		if (!aresetn || power_src) begin
			swen_ff <= reset_seq_pkg::CTRL_RESET[reset_seq_pkg::SWEN_BIT];
			fs_ff <= reset_seq_pkg::CTRL_RESET[reset_seq_pkg::FS_BIT];
		end else if (do_wr && wstrb_ff && awaddr_ff == reset_seq_pkg::CTRL_OFF) begin
			swen_ff <= wdata_ff[reset_seq_pkg::SWEN_BIT];
			fs_ff <= wdata_ff[reset_seq_pkg::FS_BIT]; // [R3]
		end
	end

	// Reset cause flags; hardware events win over a software write.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cause_ff <= reset_seq_pkg::CAUSE_RESET;
		end else if (por_active || prog_mode_exit) begin
			cause_ff <= reset_seq_pkg::CAUSE_RESET; // [R17]
		end else if (bor_trip || low_power_brownout_trip) begin
			cause_ff[reset_seq_pkg::BOR_BIT] <= 1'b0; // [R6]
			cause_ff[reset_seq_pkg::OVF_BIT] <= 1'b0;
			cause_ff[reset_seq_pkg::UNF_BIT] <= 1'b0;
			cause_ff[reset_seq_pkg::TO_BIT] <= 1'b1;
			cause_ff[reset_seq_pkg::PD_BIT] <= 1'b1;
		end else begin
			if (do_wr && wstrb_ff && awaddr_ff == reset_seq_pkg::CAUSE_OFF) begin
				cause_ff <= wdata_ff & reset_seq_pkg::CAUSE_MASK;
			end
			if (run_evt && watchdog_timeout) begin
				cause_ff[reset_seq_pkg::TO_BIT] <= 1'b0; // [R14]
				if (sleep_mode) begin
					cause_ff[reset_seq_pkg::PD_BIT] <= 1'b0;
				end
			end
			if (run_evt && reset_instr) begin
				cause_ff[reset_seq_pkg::RI_BIT] <= 1'b0; // [R15]
			end
			if (run_evt && stack_fault_reset_enable && stack_overflow) begin
				cause_ff[reset_seq_pkg::OVF_BIT] <= 1'b1; // [R16]
			end
			if (run_evt && stack_fault_reset_enable && stack_underflow) begin
				cause_ff[reset_seq_pkg::UNF_BIT] <= 1'b1;
			end
		end
	end

	// Write address and data are taken independently and held.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_ff <= 1'b1;
			awaddr_ff <= '0;
		end else if (awvalid && awready_ff) begin
			awready_ff <= 1'b0;
			awaddr_ff <= awaddr;
		end else if (bvalid_ff && bready) begin
			awready_ff <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready_ff <= 1'b1;
			wdata_ff <= '0;
			wstrb_ff <= 1'b0;
		end else if (wvalid && wready_ff) begin
			wready_ff <= 1'b0;
			wdata_ff <= wdata[7:0];
			wstrb_ff <= wstrb[0];
		end else if (bvalid_ff && bready) begin
			wready_ff <= 1'b1;
		end
	end

	// The write lands once both halves are held, then the response follows.
	assign do_wr = !awready_ff && !wready_ff && !bvalid_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= reset_seq_pkg::RESP_OKAY;
		end else if (do_wr) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= reg_mapped(awaddr_ff) ? reset_seq_pkg::RESP_OKAY :
				reset_seq_pkg::RESP_SLVERR;
		end else if (bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// Read channel: data is captured with the address, one read at a time.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_ff <= 1'b1;
			rvalid_ff <= 1'b0;
			rdata_ff <= '0;
			rresp_ff <= reset_seq_pkg::RESP_OKAY;
		end else if (arvalid && arready_ff) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b1;
			rresp_ff <= reg_mapped(araddr) ? reset_seq_pkg::RESP_OKAY :
				reset_seq_pkg::RESP_SLVERR;
			if (araddr == reset_seq_pkg::CTRL_OFF) begin
				rdata_ff <= {24'h000000, swen_ff, fs_ff, 5'h00, rdy_ff}; // [R4] [R5]
			end else if (araddr == reset_seq_pkg::CAUSE_OFF) begin
				rdata_ff <= {24'h000000, cause_ff};
			end else begin
				rdata_ff <= '0;
			end
		end else if (rvalid_ff && rready) begin
			arready_ff <= 1'b1;
			rvalid_ff <= 1'b0;
		end
	end

	// Checks on the sequencing and the registers.
	// Counts consecutive undisturbed cycles of the clear-release delay, so that the
	// ten-cycle check needs no long repetition.
	logic [reset_seq_pkg::CLR_DELAY_W-1:0] quiet_cnt_ff;
	logic quiet_dly;

	assign quiet_dly = state_ff == reset_seq_pkg::ST_DELAY && !power_src && !clr_low && rdy_ok;

	always_ff @(posedge aclk) begin
		if (!aresetn || !quiet_dly) begin
			quiet_cnt_ff <= '0;
		end else begin
			quiet_cnt_ff <= quiet_cnt_ff + 1'b1;
		end
	end

	sequence quiet_delay_s;
		quiet_dly && quiet_cnt_ff ==
			reset_seq_pkg::CLR_DELAY_W'(reset_seq_pkg::CLR_DELAY_CYCLES - 1);
	endsequence

	clear_delay_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R20]
		quiet_delay_s |=> state_ff == reset_seq_pkg::ST_RUN && !hold_ff)
		else $error("Run did not start ten cycles after clear release.");

	soft_detector_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
		brownout_mode_select == reset_seq_pkg::BO_SW ##1 brownout_mode_select ==
		reset_seq_pkg::BO_SW |-> det_on_ff == $past(swen_ff))
		else $error("Detector enable does not follow software bit.");

	fast_start_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R2] [R3]
		##1 bandgap_ff == ($past(fs_ff) && $past(brownout_mode_select == reset_seq_pkg::BO_SW ||
		brownout_mode_select == reset_seq_pkg::BO_NOSLEEP)))
		else $error("Band gap force does not match mode and fast start.");

	ctrl_read_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R4] [R5]
		arvalid && arready_ff && araddr == reset_seq_pkg::CTRL_OFF |=>
		rdata_ff[5:1] == 5'h00 && rdata_ff[0] == $past(rdy_ff))
		else $error("Control read shows wrong status or reserved bits.");

	low_power_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R6] [R7]
		low_power_brownout_trip && !por_active && !prog_mode_exit |=> hold_ff && !cause_ff[reset_seq_pkg::BOR_BIT])
		else $error("Low-power trip did not hold reset and flag it.");

	clear_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R10] [R9]
		(low_voltage_program || external_clear_enable) && !clr_level |=> hold_ff)
		else $error("Enabled clear pin low did not hold reset.");

	instr_reset_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R15]
		run_evt && reset_instr && !power_src |=> hold_ff && !cause_ff[reset_seq_pkg::RI_BIT])
		else $error("Reset instruction did not reset and clear its flag.");

	stack_fault_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R16]
		run_evt && stack_fault_reset_enable && stack_overflow && !power_src |=>
		hold_ff && cause_ff[reset_seq_pkg::OVF_BIT])
		else $error("Stack overflow reset not taken or not flagged.");

	watchdog_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R14]
		run_evt && watchdog_timeout && !power_src |=> !cause_ff[reset_seq_pkg::TO_BIT] && hold_ff)
		else $error("Watchdog reset did not clear the timeout flag.");

	ready_wait_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R22] [R19]
		state_ff == reset_seq_pkg::ST_READY && need_rdy && !rdy_ff |=>
		state_ff != reset_seq_pkg::ST_DELAY && state_ff != reset_seq_pkg::ST_RUN)
		else $error("Start-up passed before detector was ready.");

	prog_exit_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R17]
		prog_mode_exit |=> state_ff == reset_seq_pkg::ST_HOLD && cause_ff == reset_seq_pkg::CAUSE_RESET)
		else $error("Programming exit did not act as power-on reset.");

endmodule

/* tb/reset_source_sequencer_tb_top.sv */
// Self-checking bench for the reset source sequencer: start-up timing, clear pin,
// core events, detectors and the two registers over AXI4-Lite.
// Assumes POWERUP_DELAY_TIMER_CYCLES is set to 20 and the design's own assertions run alongside.
`timescale 1ns/1ps
module reset_source_sequencer_tb_top;
	logic aclk = 0, aresetn = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0;
	logic [3:0] wstrb = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [1:0] brownout_mode_select = 2'h3;
	logic low_power_brownout_n = 1, external_clear_enable = 1, low_voltage_program = 0;
	logic powerup_timer_enable_n = 0, stack_fault_reset_enable = 1, por_active = 1;
	logic brownout_low = 0, brownout_settled = 1, low_power_brownout_low = 0;
	logic external_clear_pin = 1, sw_pullup_enable = 0, watchdog_timeout = 0;
	logic reset_instr = 0, stack_overflow = 0, stack_underflow = 0;
	logic prog_mode_exit = 0, sleep_mode = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic core_reset_hold, brownout_detector_on, bandgap_force_on, clear_pin_pullup;
	logic stack_overflow_flag, stack_underflow_flag, timeout_flag_n, powerdown_flag_n;
	logic reset_instr_flag_n, por_flag_n, brownout_flag_n;
	int n_errors = 0, samples_checked = 0, n;
	logic [31:0] d;
	logic [1:0] r;

	// Design under test with a short power-up delay.
	reset_source_sequencer #(.POWERUP_DELAY_TIMER_CYCLES(20)) uut (.aclk, .aresetn, .awaddr, .awvalid,
		.awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .brownout_mode_select,
		.low_power_brownout_n, .external_clear_enable, .low_voltage_program,
		.powerup_timer_enable_n, .stack_fault_reset_enable, .por_active, .brownout_low,
		.brownout_settled, .low_power_brownout_low, .external_clear_pin, .sw_pullup_enable,
		.watchdog_timeout, .reset_instr, .stack_overflow, .stack_underflow, .prog_mode_exit,
		.sleep_mode, .core_reset_hold, .brownout_detector_on, .bandgap_force_on,
		.clear_pin_pullup, .stack_overflow_flag, .stack_underflow_flag, .timeout_flag_n,
		.powerdown_flag_n, .reset_instr_flag_n, .por_flag_n, .brownout_flag_n);

	// Free-running 125 MHz clock.
	always #4 aclk = ~aclk;

	// Compares one value and counts it.
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Counts edges until the core hold reaches a level, with a bound.
	task automatic wait_hold(input logic v, output int c);
		c = 0;
		while (core_reset_hold !== v && c < 200) begin
			@(posedge aclk);
			c++;
		end
	endtask

	// One AXI4-Lite write; address and data offered together.
	task automatic wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] rs);
		bit got;
		got = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= dat;
		wstrb <= 4'hf;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		for (int i = 0; i < 50 && !got; i++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 0;
			if (wvalid && wready) wvalid <= 0;
			if (bvalid && bready) begin
				rs = bresp;
				bready <= 0;
				got = 1;
			end
		end
		if (!got) chk("write response", 1, 0);
	endtask

	// One AXI4-Lite read.
	task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] rs);
		bit got;
		got = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		for (int i = 0; i < 50 && !got; i++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 0;
			if (rvalid && rready) begin
				dat = rdata;
				rs = rresp;
				rready <= 0;
				got = 1;
			end
		end
		if (!got) chk("read response", 1, 0);
	endtask

	// Fires one-cycle core events {underflow, overflow, watchdog, reset instruction}
	// and checks the hold, then waits for the return to run.
	task automatic pulse_event(input logic [3:0] ev, input logic exp_hold);
		@(posedge aclk);
		{stack_underflow, stack_overflow, watchdog_timeout, reset_instr} <= ev;
		@(posedge aclk);
		{stack_underflow, stack_overflow, watchdog_timeout, reset_instr} <= 4'h0;
		wait_hold(1'b1, n);
		chk("event reset", exp_hold, n < 5);
		wait_hold(1'b0, n);
	endtask

	// Power-on release: timer, then 10-cycle delay before the core runs.
	task automatic t_start();
		@(posedge aclk);
		por_active <= 0;
		wait_hold(1'b0, n);
		chk("startup window", 1, n >= 30 && n <= 40);
		$display("test start done");
	endtask

	// Register values, read-only and unimplemented bits, unmapped address.
	task automatic t_regs();
		rd(8'h00, d, r);
		chk("control value", 32'h81, d);
		rd(8'h04, d, r);
		chk("cause value", 32'h38, d);
		wr(8'h00, 32'hff, r);
		rd(8'h00, d, r);
		chk("control write", 32'hc1, d);
		rd(8'h08, d, r);
		chk("unmapped read", 32'h2, {d[29:0], r});
		wr(8'h08, 32'h0, r);
		chk("unmapped write", 2'h2, r);
		$display("test regs done");
	endtask

	// Fast start and software enable across the modes.
	task automatic t_modes();
		brownout_mode_select <= 2'h1;
		wr(8'h00, 32'h40, r);
		@(posedge aclk);
		chk("fast start mode 01", 1, bandgap_force_on);
		chk("sw disable", 0, brownout_detector_on);
		wr(8'h00, 32'h80, r);
		@(posedge aclk);
		chk("sw enable", 1, brownout_detector_on);
		chk("fast start off", 0, bandgap_force_on);
		brownout_mode_select <= 2'h2;
		wr(8'h00, 32'hc0, r);
		@(posedge aclk);
		chk("fast start mode 10", 1, bandgap_force_on);
		brownout_mode_select <= 2'h0;
		repeat (2) @(posedge aclk);
		chk("fast start mode 00", 0, bandgap_force_on);
		brownout_mode_select <= 2'h3;
		repeat (2) @(posedge aclk);
		chk("fast start mode 11", 0, bandgap_force_on);
		chk("mode 11 waits ready", 1, core_reset_hold);
		rd(8'h00, d, r);
		chk("fast start kept", 32'hc1, d);
		$display("test modes done");
	endtask

	// Clear pin: glitch, hold low past the timer, disabled function.
	task automatic t_clear();
		external_clear_pin <= 0;
		repeat (2) @(posedge aclk);
		external_clear_pin <= 1;
		repeat (10) @(posedge aclk);
		chk("glitch ignored", 0, core_reset_hold);
		chk("pull-up on", 1, clear_pin_pullup);
		por_active <= 1;
		external_clear_pin <= 0;
		repeat (3) @(posedge aclk);
		por_active <= 0;
		repeat (40) @(posedge aclk);
		chk("held by pin", 1, core_reset_hold);
		external_clear_pin <= 1;
		wait_hold(1'b0, n);
		chk("release delay", 1, n >= 10 && n <= 16);
		external_clear_enable <= 0;
		repeat (2) @(posedge aclk);
		chk("pull-up software", 0, clear_pin_pullup);
		sw_pullup_enable <= 1;
		repeat (2) @(posedge aclk);
		chk("pull-up software on", 1, clear_pin_pullup);
		external_clear_pin <= 0;
		repeat (10) @(posedge aclk);
		chk("disabled pin", 0, core_reset_hold);
		low_voltage_program <= 1;
		repeat (7) @(posedge aclk);
		chk("enabled by program bit", 1, core_reset_hold);
		external_clear_pin <= 1;
		low_voltage_program <= 0;
		wait_hold(1'b0, n);
		$display("test clear done");
	endtask

	// Core events and detector sources.
	task automatic t_events();
		pulse_event(4'h1, 1);
		chk("reset instr flag", 0, reset_instr_flag_n);
		sleep_mode <= 1;
		pulse_event(4'h2, 1);
		sleep_mode <= 0;
		chk("timeout flag", 0, timeout_flag_n);
		chk("powerdown flag", 0, powerdown_flag_n);
		pulse_event(4'h4, 1);
		chk("overflow flag", 1, stack_overflow_flag);
		stack_fault_reset_enable <= 0;
		pulse_event(4'h8, 0);
		chk("underflow ignored", 0, stack_underflow_flag);
		brownout_low <= 1;
		repeat (2) @(posedge aclk);
		chk("main trip", 1, core_reset_hold);
		brownout_low <= 0;
		wait_hold(1'b0, n);
		brownout_mode_select <= 2'h0;
		low_power_brownout_low <= 1;
		repeat (4) @(posedge aclk);
		chk("low-power disabled", 0, core_reset_hold);
		low_power_brownout_n <= 0;
		repeat (4) @(posedge aclk);
		chk("low-power trip", 1, core_reset_hold);
		chk("brownout flag", 0, brownout_flag_n);
		low_power_brownout_low <= 0;
		wait_hold(1'b0, n);
		wr(8'h04, 32'hff, r);
		@(posedge aclk);
		prog_mode_exit <= 1;
		@(posedge aclk);
		prog_mode_exit <= 0;
		wait_hold(1'b1, n);
		wait_hold(1'b0, n);
		chk("program exit delay", 1, n >= 30 && n <= 40);
		rd(8'h04, d, r);
		chk("program exit cause", 32'h38, d);
		chk("por flag", 0, por_flag_n);
		$display("test events done");
	endtask

	// Verdict and end of run.
	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Watchdog against a hung handshake or sequence.
	initial begin
		repeat (20000) @(posedge aclk);
		n_errors++;
		final_report();
	end

	// Main sequence.
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1;
		t_start();
		t_regs();
		t_modes();
		t_clear();
		t_events();
		final_report();
	end
endmodule
